/* mie_core.sv */
// Execution datapath for a subset of an 8-bit controller's instructions.
// Assumes a decoder supplies one instruction per cycle when instr_valid is high,
// and a program ROM answers rom_data one cycle after rom_addr is presented.
// The file register array is cleared by reset, so it maps to flops, not a RAM.
// An instruction offered while busy is high is dropped; the decoder re-offers it.
`timescale 1ns/1ps
module mie_core #(
    parameter int FILE_DEPTH = 128 // Number of file registers
) (
    input wire logic mclk, // Core clock, 40 MHz
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic instr_valid, // Instruction present this cycle
    input wire mie_pkg::mie_instr_t instr, // Decoded instruction
    input wire logic [2:0] table_pointer_high, // Table pointer high bits
    input wire logic [13:0] rom_data, // ROM word, one cycle after address
    output logic [10:0] rom_addr, // ROM address for table read
    output logic rom_rd, // ROM read strobe
    output logic busy, // Table read second cycle, stall decoder
    output logic [7:0] accumulator, // Accumulator
    output logic [7:0] timer0_mode_reg, // Timer0 mode register
    output logic [7:0] table_high_data, // Table high data register
    output logic zero_flag, // Zero status flag
    output logic [7:0] file_rd_data // Addressed file register, registered
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] file_mem [FILE_DEPTH];
    logic [7:0] next_accumulator;
    logic [7:0] next_timer0_mode_reg;
    logic [7:0] next_table_high_data;
    logic next_zero_flag;
    logic [10:0] next_rom_addr;
    logic next_rom_rd;
    logic next_busy;
    logic [7:0] next_file_rd_data;
    mie_pkg::mie_tstate_t tstate;
    mie_pkg::mie_tstate_t next_tstate;
    mie_pkg::mie_alu_t alu_res;
    logic [7:0] file_data;
    logic file_we;
    logic take;
    logic table_start;

    // Zero test on a result byte
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == mie_pkg::ZERO_BYTE);
    endfunction

    // True when an address falls inside the array; shared by read and write
    function automatic logic in_file(input logic [6:0] a);
        in_file = (int'(a) < FILE_DEPTH);
    endfunction

    // Instructions are taken only outside the table read second cycle
    assign take = instr_valid && (tstate == mie_pkg::MIE_T_IDLE);
    assign table_start = take && (instr.op == mie_pkg::MIE_TABLE);
    // Addresses beyond a shrunken array read as the reset value and are never written
    assign file_data = in_file(instr.faddr) ? file_mem[instr.faddr]
        : mie_pkg::FILE_RST;
    assign file_we = take && alu_res.to_reg && in_file(instr.faddr);

    // ------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------
    mie_alu u_alu (
        .instr(instr),
        .accumulator(accumulator),
        .file_data(file_data),
        .timer0_mode_reg(timer0_mode_reg),
        .res(alu_res)
    );

    // ------------------------------------------------------------
    // Table read sequencer
    // ------------------------------------------------------------
    // Cycle walk of a table read taken at edge N:
    //   edge N   : rom_addr = {pointer, accumulator}; rom_rd and busy rise
    //   cycle N+1: the ROM drives rom_data; an offered instruction is dropped
    //   edge N+1 : accumulator and table_high_data load; rom_rd and busy fall
    //   edge N+2 : the next instruction may be taken
    // Next sequencer values
    always_comb begin
        next_tstate = tstate;
        next_rom_addr = rom_addr;
        next_rom_rd = 1'b0;
        next_busy = 1'b0;
        case (tstate)
            mie_pkg::MIE_T_IDLE: begin
                if (table_start) begin
                    next_rom_addr = {table_pointer_high, accumulator};
                    next_rom_rd = 1'b1;
                    next_busy = 1'b1;
                    next_tstate = mie_pkg::MIE_T_FETCH;
                end
            end
            mie_pkg::MIE_T_FETCH: begin
                // The ROM word is captured at the end of this cycle
                next_tstate = mie_pkg::MIE_T_IDLE;
            end
            default: begin
                next_tstate = mie_pkg::MIE_T_IDLE;
            end
        endcase
    end

    // Register the sequencer; rom_addr holds until the next table read
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            tstate <= mie_pkg::MIE_T_IDLE;
            rom_addr <= '0;
            rom_rd <= 1'b0;
            busy <= 1'b0;
        end else begin
            tstate <= next_tstate;
            rom_addr <= next_rom_addr;
            rom_rd <= next_rom_rd;
            busy <= next_busy;
        end
    end

    // ------------------------------------------------------------
    // Architectural registers
    // ------------------------------------------------------------
    // Next values; the table read and a taken instruction never meet in one cycle
    always_comb begin
        next_accumulator = accumulator;
        next_timer0_mode_reg = timer0_mode_reg;
        next_table_high_data = table_high_data;
        if (tstate == mie_pkg::MIE_T_FETCH) begin
            // Second cycle: ROM word is back; flags untouched
            next_accumulator = rom_data[mie_pkg::DATA_W-1:0];
            next_table_high_data = {mie_pkg::HIGH_PAD,
                rom_data[mie_pkg::ROM_W-1:mie_pkg::DATA_W]};
        end else if (take && !table_start) begin
            if (alu_res.to_acc) begin
                next_accumulator = alu_res.value;
            end
            if (alu_res.to_tmr) begin
                next_timer0_mode_reg = alu_res.value;
            end
        end
    end

    // Register the accumulator and the two moved registers
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            accumulator <= mie_pkg::ACC_RST;
            timer0_mode_reg <= mie_pkg::TMR_RST;
            table_high_data <= mie_pkg::TABLE_HIGH_DATA_RST;
        end else begin
            accumulator <= next_accumulator;
            timer0_mode_reg <= next_timer0_mode_reg;
            table_high_data <= next_table_high_data;
        end
    end

    // ------------------------------------------------------------
    // Status flag
    // ------------------------------------------------------------
    // Only the two XOR forms touch the flag; swap, moves and the table read
    // leave it, so a test after a table read still sees the last XOR.
    always_comb begin
        next_zero_flag = zero_flag;
        if (take && alu_res.zero_upd) begin
            next_zero_flag = is_zero(alu_res.value);
        end
    end

    // Register the flag
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            zero_flag <= 1'b0;
        end else begin
            zero_flag <= next_zero_flag;
        end
    end

    // ------------------------------------------------------------
    // File read-back
    // ------------------------------------------------------------
    // Shows the cell addressed in the previous cycle, after any write in that
    // cycle, so a result stored back to a register can be watched at the pins.
    always_comb begin
        next_file_rd_data = file_data;
        if (file_we) begin
            next_file_rd_data = alu_res.value;
        end
    end

    // Register the read-back value
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            file_rd_data <= mie_pkg::FILE_RST;
        end else begin
            file_rd_data <= next_file_rd_data;
        end
    end

    // ------------------------------------------------------------
    // File register array
    // ------------------------------------------------------------
    // Cleared on reset so a swap or XOR never reads an unwritten cell; the
    // price is a reset tree over the whole array instead of a plain RAM.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < FILE_DEPTH; i++) begin
                file_mem[i] <= mie_pkg::FILE_RST;
            end
        end else if (file_we) begin
            file_mem[instr.faddr] <= alu_res.value;
        end
    end

endmodule

/* mie_pkg.sv */
// Package for the instruction execution subset datapath.
// Assumes a single core clock domain; shared by the core and the ALU module.
package mie_pkg;

    // ------------------------------------------------------------
    // Widths and field layout
    // ------------------------------------------------------------
    localparam int DATA_W = 8;
    localparam int FADDR_W = 7;
    localparam int ROM_W = 14;
    localparam int PTR_W = 3;
    localparam int ROM_ADDR_W = 11;
    localparam int HIGH_W = 6;
    localparam int NIB_W = 4;
    localparam logic [6:0] FADDR_MAX = 7'h7f;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_REG = 1'b1;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] TMR_RST = 8'h00;
    localparam logic [7:0] TABLE_HIGH_DATA_RST = 8'h00;
    localparam logic [7:0] FILE_RST = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [1:0] HIGH_PAD = 2'h0;

    // Operation codes presented by the decoder
    typedef enum logic [2:0] {
        MIE_NOP = 3'h0,
        MIE_SWAP = 3'h1,
        MIE_LDTM = 3'h2,
        MIE_RDTM = 3'h3,
        MIE_TABLE = 3'h4,
        MIE_XORR = 3'h5,
        MIE_XORI = 3'h6
    } mie_op_t;

    // One decoded instruction
    typedef struct packed {
        mie_op_t op;
        logic [6:0] faddr;
        logic dest;
        logic [7:0] imm;
    } mie_instr_t;

    // ALU answer
    typedef struct packed {
        logic [7:0] value;
        logic zero_upd;
        logic to_reg;
        logic to_acc;
        logic to_tmr;
    } mie_alu_t;

    // Table read state
    typedef enum logic [0:0] {
        MIE_T_IDLE = 1'b0,
        MIE_T_FETCH = 1'b1
    } mie_tstate_t;

endpackage

/* mie_alu.sv */
// Combinational ALU for swap, exclusive-OR and timer mode moves.
// Assumes operands come from registers in the core on the same clock.
`timescale 1ns/1ps
module mie_alu (
    input wire mie_pkg::mie_instr_t instr, // Decoded instruction
    input wire logic [7:0] accumulator, // Accumulator value
    input wire logic [7:0] file_data, // Addressed file register
    input wire logic [7:0] timer0_mode_reg, // Timer0 mode value
    output mie_pkg::mie_alu_t res // Result and write strobes
);

    // Swap the two nibbles of a byte
    function automatic logic [7:0] swap_nib(input logic [7:0] v);
        swap_nib = {v[mie_pkg::NIB_W-1:0], v[mie_pkg::DATA_W-1:mie_pkg::NIB_W]};
    endfunction

    // Select result and which destinations are written
    always_comb begin
        res = '0;
        case (instr.op)
            mie_pkg::MIE_SWAP: begin
                res.value = swap_nib(file_data);
                res.to_reg = (instr.dest == mie_pkg::DEST_REG);
                res.to_acc = (instr.dest == mie_pkg::DEST_ACC);
            end
            mie_pkg::MIE_LDTM: begin
                res.value = accumulator;
                res.to_tmr = 1'b1;
            end
            mie_pkg::MIE_RDTM: begin
                res.value = timer0_mode_reg;
                res.to_acc = 1'b1;
            end
            mie_pkg::MIE_XORR: begin
                res.value = accumulator ^ file_data;
                res.zero_upd = 1'b1;
                res.to_reg = (instr.dest == mie_pkg::DEST_REG);
                res.to_acc = (instr.dest == mie_pkg::DEST_ACC);
            end
            mie_pkg::MIE_XORI: begin
                res.value = accumulator ^ instr.imm;
                res.zero_upd = 1'b1;
                res.to_acc = 1'b1;
            end
            default: begin
                res = '0;
            end
        endcase
    end

endmodule

/* mie_checker.sv */
// Port-level assertions for the execution subset datapath.
// Assumes one mclk domain; bound onto every instance of mie_core.
`timescale 1ns/1ps
module mie_checker (
    input wire logic mclk, // Core clock
    input wire logic rst_n, // Asynchronous reset, active low
    input wire logic instr_valid, // Instruction present
    input wire mie_pkg::mie_instr_t instr, // Decoded instruction
    input wire logic [2:0] table_pointer_high, // Pointer bits
    input wire logic [13:0] rom_data, // ROM word
    input wire logic [10:0] rom_addr, // ROM address
    input wire logic rom_rd, // ROM read strobe
    input wire logic busy, // Second table cycle
    input wire logic [7:0] accumulator, // Accumulator
    input wire logic [7:0] timer0_mode_reg, // Timer0 mode register
    input wire logic [7:0] table_high_data, // Table high data
    input wire logic zero_flag, // Zero flag
    input wire logic [7:0] file_rd_data // Registered file read-back
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    // Busy cycles refuse instructions, so only idle takes count
    wire logic taken = instr_valid && !busy;
    property p_xori; taken && instr.op == mie_pkg::MIE_XORI |=>
        accumulator == ($past(accumulator) ^ $past(instr.imm)); endproperty
    // A stored-back XOR shows its result on the read-back port, not the accumulator
    property p_zero; taken && instr.op inside {mie_pkg::MIE_XORI, mie_pkg::MIE_XORR} |=>
        zero_flag == ((($past(instr.op) == mie_pkg::MIE_XORR && $past(instr.dest)) ?
        file_rd_data : accumulator) == 8'h00); endproperty
    property p_ldtm; taken && instr.op == mie_pkg::MIE_LDTM |=>
        timer0_mode_reg == $past(accumulator) && $stable(accumulator); endproperty
    property p_rdtm; taken && instr.op == mie_pkg::MIE_RDTM |=>
        accumulator == $past(timer0_mode_reg); endproperty
    property p_tbl_addr; taken && instr.op == mie_pkg::MIE_TABLE |=>
        rom_rd && busy && rom_addr == {$past(table_pointer_high), $past(accumulator)}; endproperty
    property p_tbl_data; rom_rd |=> accumulator == $past(rom_data[7:0]) &&
        table_high_data == {2'h0, $past(rom_data[13:8])} && !busy && !rom_rd; endproperty
    property p_keep; taken && instr.op inside {mie_pkg::MIE_SWAP, mie_pkg::MIE_LDTM,
        mie_pkg::MIE_RDTM, mie_pkg::MIE_TABLE} |=> $stable(zero_flag); endproperty
    property p_dest; taken && instr.dest && instr.op inside {mie_pkg::MIE_SWAP,
        mie_pkg::MIE_XORR} |=> $stable(accumulator); endproperty
    a_xori: assert property (p_xori) else $error("xor immediate result wrong");
    a_zero: assert property (p_zero) else $error("zero flag wrong");
    a_ldtm: assert property (p_ldtm) else $error("timer mode load wrong");
    a_rdtm: assert property (p_rdtm) else $error("timer mode read wrong");
    a_tbl_addr: assert property (p_tbl_addr) else $error("table address wrong");
    a_tbl_data: assert property (p_tbl_data) else $error("table data wrong");
    a_keep: assert property (p_keep) else $error("zero flag disturbed");
    a_dest: assert property (p_dest) else $error("accumulator written");
    c_table: cover property (taken && instr.op == mie_pkg::MIE_TABLE);
    c_refuse: cover property (busy && instr_valid);
    c_zero: cover property ((taken && instr.op == mie_pkg::MIE_XORI) ##1 zero_flag);
    c_store: cover property (taken && instr.op == mie_pkg::MIE_XORR && instr.dest);
endmodule
bind mie_core mie_checker chk_i (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr(instr), .table_pointer_high(table_pointer_high), .rom_data(rom_data),
    .rom_addr(rom_addr), .rom_rd(rom_rd), .busy(busy), .accumulator(accumulator),
    .timer0_mode_reg(timer0_mode_reg), .table_high_data(table_high_data),
    .zero_flag(zero_flag), .file_rd_data(file_rd_data));

/* testbench.sv */
// Self-checking bench for mie_core: drives decoder and ROM side directly.
// Assumes inputs change 1 ns after each rising mclk edge.
`timescale 1ns/1ps
module testbench;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic instr_valid = 1'b0;
    mie_pkg::mie_instr_t instr = '0;
    logic [2:0] table_pointer_high = 3'h0;
    logic [13:0] rom_data = 14'h0000;
    logic [10:0] rom_addr;
    logic rom_rd, busy, zero_flag;
    logic [7:0] accumulator, timer0_mode_reg, table_high_data, file_rd_data;
    logic [7:0] acc_m = 8'h00;
    logic z_old;
    int failures = 0;
    int checked = 0;
    // ------------------------------------------------------------
    // Clock and device
    // ------------------------------------------------------------
    always #12.5 mclk = ~mclk;
    mie_core uut (.mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid), .instr(instr),
        .table_pointer_high(table_pointer_high), .rom_data(rom_data), .rom_addr(rom_addr),
        .rom_rd(rom_rd), .busy(busy), .accumulator(accumulator),
        .timer0_mode_reg(timer0_mode_reg), .table_high_data(table_high_data),
        .zero_flag(zero_flag), .file_rd_data(file_rd_data));
    task automatic chk(input logic [13:0] seen, input logic [13:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // Valid is left high so back-to-back issues never assign it twice per step
    task automatic issue(input mie_pkg::mie_op_t op, input logic [6:0] fa, input logic d,
        input logic [7:0] imm);
        instr = '{op, fa, d, imm};
        instr_valid = 1'b1;
        @(posedge mclk);
        #1;
    endtask
    task automatic idle();
        instr_valid = 1'b0;
        @(posedge mclk);
        #1;
    endtask
    // Table read, with a refused instruction held during the busy cycle
    task automatic do_table(input logic [2:0] ptr, input logic [13:0] word);
        z_old = zero_flag;
        table_pointer_high = ptr;
        issue(mie_pkg::MIE_TABLE, 7'h00, 1'b0, 8'h00);
        chk(rom_rd, 1'b1);
        chk(rom_addr, {ptr, acc_m});
        rom_data = word;
        issue(mie_pkg::MIE_XORI, 7'h00, 1'b0, 8'hff);
        rom_data = ~word; // Released ROM bus no longer shows the word
        acc_m = word[7:0];
        chk(accumulator, acc_m);
        chk(table_high_data, {2'h0, word[13:8]});
        chk(busy, 1'b0);
        chk(zero_flag, z_old);
        idle();
        chk(accumulator, acc_m);
    endtask
    task automatic t_timer();
        do_table(3'h5, 14'h1eaa);
        issue(mie_pkg::MIE_LDTM, 7'h00, 1'b0, 8'h00);
        chk(timer0_mode_reg, 8'haa);
        chk(accumulator, 8'haa);
        issue(mie_pkg::MIE_XORI, 7'h00, 1'b0, 8'h0f);
        chk(accumulator, 8'ha5);
        issue(mie_pkg::MIE_RDTM, 7'h00, 1'b0, 8'h00);
        chk(accumulator, 8'haa);
        acc_m = 8'haa;
        idle();
    endtask
    // Store-back and swap through the top file address, then zero by both XORs
    task automatic t_xor();
        do_table(3'h2, 14'h00f0);
        issue(mie_pkg::MIE_XORI, 7'h00, 1'b0, 8'ha6);
        chk(accumulator, 8'h56);
        chk(zero_flag, 1'b0);
        issue(mie_pkg::MIE_XORR, 7'h7f, 1'b1, 8'h00);
        chk(file_rd_data, 8'h56);
        chk(accumulator, 8'h56);
        issue(mie_pkg::MIE_SWAP, 7'h7f, 1'b1, 8'h00);
        chk(file_rd_data, 8'h65);
        chk(accumulator, 8'h56);
        chk(zero_flag, 1'b0);
        issue(mie_pkg::MIE_XORR, 7'h7f, 1'b0, 8'h00);
        chk(accumulator, 8'h33);
        chk(file_rd_data, 8'h65);
        issue(mie_pkg::MIE_XORI, 7'h00, 1'b0, 8'h33);
        chk(accumulator, 8'h00);
        chk(zero_flag, 1'b1);
        issue(mie_pkg::MIE_SWAP, 7'h7f, 1'b0, 8'h00);
        chk(accumulator, 8'h56);
        chk(zero_flag, 1'b1);
        issue(mie_pkg::MIE_XORI, 7'h00, 1'b0, 8'h33);
        chk(accumulator, 8'h65);
        issue(mie_pkg::MIE_XORR, 7'h7f, 1'b1, 8'h00);
        chk(file_rd_data, 8'h00);
        chk(zero_flag, 1'b1);
        chk(accumulator, 8'h65);
        acc_m = 8'h65;
        idle();
    endtask
    task automatic wrap_up();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge mclk);
        #1;
        rst_n = 1'b1;
        chk(accumulator, 8'h00);
        do_table(3'h0, 14'h35aa);
        do_table(3'h7, 14'h3f00);
        t_timer();
        t_xor();
        wrap_up();
    end
    // Whole run is well under 100 cycles
    initial begin
        #20000;
        failures++;
        wrap_up();
    end
endmodule
